//--- common/cpu_exception_sequencer_regs.svh
`ifndef CPU_EXCEPTION_SEQUENCER_REGS_SVH
`define CPU_EXCEPTION_SEQUENCER_REGS_SVH

// ========
// Register offsets (byte addresses)
`define VBR_OFFSET 8'h00
`define STATUS_WORD_OFFSET 8'h04
`define SEQ_STATE_OFFSET 8'h08
`define LAST_FETCH_OFFSET 8'h0C

// ========
// Reset values and status word fields
`define VBR_RESET 32'h00000000
`define STATUS_WORD_RESET 32'h000000F0
`define MASK_LSB 4
`define MASK_ALL 4'hF

// ========
// Vector numbers
`define VEC_POR_PC 8'h00
`define VEC_MRS_PC 8'h02
`define VEC_ILLEGAL 8'h04
`define VEC_SLOT_ILLEGAL 8'h06
`define VEC_ADDR_CPU 8'h09
`define VEC_ADDR_XFER 8'h0A
`define VEC_NMI 8'h0B
`define VEC_BREAK 8'h0C
`define VEC_DEBUG 8'h0E
`define VEC_TRAP_BASE 3'h1
`define VEC_EXT_FIRST 8'h40

// ========
// Stack frame and bus answers
`define FRAME_WORD 32'h00000004
`define FRAME_BYTES 32'h00000008
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- common/cpu_exception_sequencer_pkg.sv
package cpu_exception_sequencer_pkg;

    // ========
    // Sequencer states
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_RST_HOLD,
        ST_RST_PC,
        ST_RST_SP,
        ST_FLUSH,
        ST_PUSH_SR,
        ST_PUSH_PC,
        ST_FETCH
    } seq_state_e;

    // ========
    // Source picked in the idle state
    typedef enum logic [2:0] {
        SRC_NONE,
        SRC_POR,
        SRC_MRS,
        SRC_ADDR,
        SRC_IRQ,
        SRC_INSTR
    } exc_src_e;

    // ========
    // Decoder report for the current instruction
    typedef struct packed {
        logic valid;
        logic undefined;
        logic in_delay_slot;
        logic pc_modifying;
        logic trap;
        logic [7:0] trap_imm;
        logic addr_err_cpu;
        logic addr_err_xfer;
    } dec_s;

    // Interrupt request from the controller
    typedef struct packed {
        logic req;
        logic [3:0] level;
        logic [7:0] vector;
    } irq_s;

    // Memory bus request
    typedef struct packed {
        logic req;
        logic write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mem_s;

endpackage : cpu_exception_sequencer_pkg

//--- src/cpu_exception_sequencer.sv
// Function
// - Power-on reset on pin rise or watchdog
// - Manual reset on manual pin rise
// - Address error flagged at decode, waits completion
// - Trap instruction starts trap processing
// - Undefined opcode outside slot: general illegal
// - Slot undefined or PC-modifying: slot illegal
// - Power-on loads PC/SP from 0, 4
// - Manual reset loads PC/SP from 8, 12
// - Reset clears vector base, sets mask ones
// - Other exceptions push status word, PC
// - Interrupt writes its level into mask
// - Address and instruction exceptions keep mask
// - Fetch handler from table, then run it
// - Distinct vector number per source, own entry
// - Reset fetch address is vector times four
// - Others fetch at base plus vector times four
// - Vector 9 CPU, 10 transfer-master address error
// - Trap selects user vector 32 to 63
// - Priority: reset, address, interrupt, instruction
// - Manual reset waits for bus cycle end
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "cpu_exception_sequencer_regs.svh"
module cpu_exception_sequencer
    import cpu_exception_sequencer_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Reset sources, pins active low
    input wire logic power_on_reset_n,
    input wire logic manual_reset_n,
    input wire logic watchdog_overflow,
    // Decoder and pipeline
    input wire dec_s dec,
    input wire logic exec_done,
    input wire logic [31:0] core_pc,
    input wire logic [31:0] stack_pointer_gpr,
    output logic core_hold,
    output logic pipe_flush,
    output logic pc_load,
    output logic [31:0] pc_value,
    output logic sp_load,
    output logic [31:0] sp_value,
    output logic [31:0] status_word,
    output logic [31:0] vector_base_reg,
    // Interrupt controller
    input wire irq_s irq,
    output logic irq_ack,
    // Memory bus
    output mem_s mem,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    input wire logic bus_busy
);
    // ========
    // Declarations
    seq_state_e state_ff;
    exc_src_e src;
    mem_s mem_ff;
    logic por_pin_ff, mrs_pin_ff;
    logic por_pend_ff, mrs_pend_ff, addr_pend_ff, instr_pend_ff;
    logic [7:0] addr_vec_ff, instr_vec_ff, vec_ff, nxt_vec, instr_vec_det, aw_addr_ff;
    logic [31:0] vbr_ff, sr_ff, sr_save_ff, pc_save_ff, sp_save_ff, last_fetch_ff;
    logic pc_load_ff, sp_load_ff, flush_ff, irq_ack_ff;
    logic [31:0] pc_value_ff, sp_value_ff, rst_addr, exc_addr, w_data_ff, rdata_ff;
    logic take, irq_ok, illegal_det, slot_det, trap_det;
    logic aw_have_ff, w_have_ff, bvalid_ff, rvalid_ff, wr_en, wr_hit;
    logic [3:0] w_strb_ff;
    logic [1:0] bresp_ff, rresp_ff;
    // Interrupt vectors that the table assigns
    function automatic logic irq_vec_legal(input logic [7:0] v);
        irq_vec_legal = (v == `VEC_NMI) || (v == `VEC_BREAK) || (v == `VEC_DEBUG) ||
                        (v >= `VEC_EXT_FIRST);
    endfunction : irq_vec_legal
    // Byte lane merge for register writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        merge = (old & ~m) | (d & m);
    endfunction : merge
    // ========
    // Source detection
    assign illegal_det = dec.valid && dec.undefined && !dec.in_delay_slot;
    assign slot_det = dec.valid && dec.in_delay_slot && (dec.undefined || dec.pc_modifying);
    assign trap_det = dec.valid && dec.trap && !dec.in_delay_slot;
    assign irq_ok = irq.req && irq_vec_legal(irq.vector) &&
                    (irq.level > sr_ff[`MASK_LSB +: 4]);
    // Instruction vector; trap folds its immediate into 32..63
    assign instr_vec_det = slot_det ? `VEC_SLOT_ILLEGAL :
                           illegal_det ? `VEC_ILLEGAL :
                           {`VEC_TRAP_BASE, dec.trap_imm[4:0]};
    // Fixed priority pick in idle
    always_comb begin
        src = SRC_NONE;
        nxt_vec = vec_ff;
        if (state_ff == ST_IDLE && power_on_reset_n) begin
            if (por_pend_ff) begin
                src = SRC_POR;
                nxt_vec = `VEC_POR_PC;
            end else if (mrs_pend_ff && manual_reset_n && !bus_busy) begin
                src = SRC_MRS;
                nxt_vec = `VEC_MRS_PC;
            end else if (!manual_reset_n || mrs_pend_ff) begin
                src = SRC_NONE;
            end else if (addr_pend_ff && exec_done) begin
                src = SRC_ADDR;
                nxt_vec = addr_vec_ff;
            end else if (irq_ok) begin
                src = SRC_IRQ;
                nxt_vec = irq.vector;
            end else if (instr_pend_ff) begin
                src = SRC_INSTR;
                nxt_vec = instr_vec_ff;
            end
        end
    end
    assign take = (src != SRC_NONE);
    // ========
    // Pin samplers start low: a high pin at release starts
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            por_pin_ff <= 1'b0;
            mrs_pin_ff <= 1'b0;
        end else begin
            por_pin_ff <= power_on_reset_n;
            mrs_pin_ff <= manual_reset_n;
        end
    end
    // Reset pending flags, set wins over clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            por_pend_ff <= 1'b0;
            mrs_pend_ff <= 1'b0;
        end else begin
            if ((power_on_reset_n && !por_pin_ff) || watchdog_overflow) begin
                por_pend_ff <= 1'b1;
            end else if (src == SRC_POR) begin
                por_pend_ff <= 1'b0;
            end
            if (manual_reset_n && !mrs_pin_ff && power_on_reset_n) begin
                mrs_pend_ff <= 1'b1;
            end else if (src == SRC_MRS || src == SRC_POR || !power_on_reset_n) begin
                mrs_pend_ff <= 1'b0;
            end
        end
    end
    // Address error and instruction pending flags
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            addr_pend_ff <= 1'b0;
            addr_vec_ff <= 8'h00;
            instr_pend_ff <= 1'b0;
            instr_vec_ff <= 8'h00;
        end else if (!power_on_reset_n || !manual_reset_n || src == SRC_POR ||
                     src == SRC_MRS) begin
            addr_pend_ff <= 1'b0;
            instr_pend_ff <= 1'b0;
        end else begin
            if (dec.valid && (dec.addr_err_cpu || dec.addr_err_xfer)) begin
                addr_pend_ff <= 1'b1;
                addr_vec_ff <= dec.addr_err_cpu ? `VEC_ADDR_CPU : `VEC_ADDR_XFER;
            end else if (src == SRC_ADDR) begin
                addr_pend_ff <= 1'b0;
            end
            if (illegal_det || slot_det || trap_det) begin
                instr_pend_ff <= 1'b1;
                instr_vec_ff <= instr_vec_det;
            end else if (src == SRC_INSTR || src == SRC_ADDR) begin
                instr_pend_ff <= 1'b0; // Faulting instruction is discarded
            end
        end
    end
    // ========
    // Fetch addresses
    assign rst_addr = {22'h000000, vec_ff, 2'h0};
    assign exc_addr = vbr_ff + {22'h000000, vec_ff, 2'h0};
    // Sequencer and memory bus master
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= ST_IDLE;
            mem_ff <= '0;
            vec_ff <= 8'h00;
            pc_save_ff <= '0;
            sp_save_ff <= '0;
            last_fetch_ff <= '0;
            pc_value_ff <= '0;
            sp_value_ff <= '0;
            pc_load_ff <= 1'b0;
            sp_load_ff <= 1'b0;
            flush_ff <= 1'b0;
            irq_ack_ff <= 1'b0;
        end else begin
            pc_load_ff <= 1'b0;
            sp_load_ff <= 1'b0;
            flush_ff <= 1'b0;
            irq_ack_ff <= 1'b0;
            if (!power_on_reset_n) begin
                state_ff <= ST_RST_HOLD;
                mem_ff.req <= 1'b0;
            end else begin
                unique case (state_ff)
                    ST_RST_HOLD: begin
                        state_ff <= ST_IDLE;
                    end
                    ST_IDLE: begin
                        vec_ff <= nxt_vec;
                        pc_save_ff <= core_pc;
                        sp_save_ff <= stack_pointer_gpr;
                        irq_ack_ff <= (src == SRC_IRQ);
                        if (src == SRC_POR || src == SRC_MRS) begin
                            state_ff <= ST_RST_PC;
                            mem_ff.req <= 1'b1;
                            mem_ff.write <= 1'b0;
                            mem_ff.addr <= {22'h000000, nxt_vec, 2'h0};
                        end else if (take) begin
                            state_ff <= ST_FLUSH;
                        end
                    end
                    ST_RST_PC: begin
                        if (mem_ack) begin
                            pc_value_ff <= mem_rdata;
                            mem_ff.addr <= rst_addr + `FRAME_WORD;
                            state_ff <= ST_RST_SP;
                        end
                    end
                    ST_RST_SP: begin
                        if (mem_ack) begin
                            mem_ff.req <= 1'b0;
                            sp_value_ff <= mem_rdata;
                            pc_load_ff <= 1'b1;
                            sp_load_ff <= 1'b1;
                            last_fetch_ff <= rst_addr;
                            state_ff <= ST_IDLE;
                        end
                    end
                    ST_FLUSH: begin
                        flush_ff <= 1'b1;
                        state_ff <= ST_PUSH_SR;
                        mem_ff.req <= 1'b1;
                        mem_ff.write <= 1'b1;
                        mem_ff.addr <= sp_save_ff - `FRAME_WORD;
                        mem_ff.wdata <= sr_save_ff;
                    end
                    ST_PUSH_SR: begin
                        if (mem_ack) begin
                            mem_ff.addr <= sp_save_ff - `FRAME_BYTES;
                            mem_ff.wdata <= pc_save_ff;
                            state_ff <= ST_PUSH_PC;
                        end
                    end
                    ST_PUSH_PC: begin
                        if (mem_ack) begin
                            mem_ff.write <= 1'b0;
                            mem_ff.addr <= exc_addr;
                            state_ff <= ST_FETCH;
                        end
                    end
                    ST_FETCH: begin
                        if (mem_ack) begin
                            mem_ff.req <= 1'b0;
                            pc_value_ff <= mem_rdata;
                            sp_value_ff <= sp_save_ff - `FRAME_BYTES;
                            pc_load_ff <= 1'b1;
                            sp_load_ff <= 1'b1;
                            last_fetch_ff <= exc_addr;
                            state_ff <= ST_IDLE;
                        end
                    end
                endcase
            end
        end
    end
    // ========
    // Vector base and status word; hardware wins over software
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vbr_ff <= `VBR_RESET;
            sr_ff <= `STATUS_WORD_RESET;
            sr_save_ff <= `STATUS_WORD_RESET;
        end else if (src == SRC_POR || src == SRC_MRS) begin
            vbr_ff <= `VBR_RESET;
            sr_ff[`MASK_LSB +: 4] <= `MASK_ALL;
        end else if (src == SRC_IRQ) begin
            sr_save_ff <= sr_ff;
            sr_ff[`MASK_LSB +: 4] <= irq.level;
        end else if (take) begin
            sr_save_ff <= sr_ff;
        end else if (wr_en && aw_addr_ff == `VBR_OFFSET) begin
            vbr_ff <= merge(vbr_ff, w_data_ff, w_strb_ff);
        end else if (wr_en && aw_addr_ff == `STATUS_WORD_OFFSET) begin
            sr_ff <= merge(sr_ff, w_data_ff, w_strb_ff);
        end
    end
    // ========
    // AXI4-Lite write channels
    assign wr_en = aw_have_ff && w_have_ff && !bvalid_ff;
    assign wr_hit = (aw_addr_ff == `VBR_OFFSET) || (aw_addr_ff == `STATUS_WORD_OFFSET) ||
                    (aw_addr_ff == `SEQ_STATE_OFFSET) || (aw_addr_ff == `LAST_FETCH_OFFSET);
    // Capture of address and data, then response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            aw_addr_ff <= 8'h00;
            w_data_ff <= 32'h00000000;
            w_strb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_ff <= 1'b1;
                aw_addr_ff <= {s_axi_awaddr[7:2], 2'h0};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_ff <= 1'b1;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end
            if (wr_en) begin
                aw_have_ff <= 1'b0;
                w_have_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end
    // AXI4-Lite read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= `RESP_OKAY;
            unique case ({s_axi_araddr[7:2], 2'h0})
                `VBR_OFFSET: rdata_ff <= vbr_ff;
                `STATUS_WORD_OFFSET: rdata_ff <= sr_ff;
                `SEQ_STATE_OFFSET: rdata_ff <= {12'h000, por_pend_ff, mrs_pend_ff, addr_pend_ff,
                                                instr_pend_ff, vec_ff, 4'h0, state_ff};
                `LAST_FETCH_OFFSET: rdata_ff <= last_fetch_ff;
                default: begin
                    rdata_ff <= 32'h00000000;
                    rresp_ff <= `RESP_SLVERR;
                end
            endcase
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end
    // ========
    // Outputs
    assign s_axi_awready = !aw_have_ff && !bvalid_ff;
    assign s_axi_wready = !w_have_ff && !bvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign core_hold = (state_ff != ST_IDLE) || !power_on_reset_n || !manual_reset_n ||
                       por_pend_ff || mrs_pend_ff;
    assign pipe_flush = flush_ff;
    assign pc_load = pc_load_ff;
    assign pc_value = pc_value_ff;
    assign sp_load = sp_load_ff;
    assign sp_value = sp_value_ff;
    assign status_word = sr_ff;
    assign vector_base_reg = vbr_ff;
    assign irq_ack = irq_ack_ff;
    assign mem = mem_ff;

endmodule : cpu_exception_sequencer

//--- dv/cpu_mem_model.sv
`timescale 1ns/1ps
module cpu_mem_model
    import cpu_exception_sequencer_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus request and answer
    input wire mem_s mem,
    input wire logic [3:0] wait_cycles,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    logic [3:0] cnt_ff;
    logic hit;
    assign hit = mem.req && !mem_ack && cnt_ff == wait_cycles;
    // One-cycle answer after wait_cycles, aligned words only
    always_ff @(posedge aclk) begin
        if (!aresetn || mem_ack || !mem.req) begin
            cnt_ff <= 4'h0;
            mem_ack <= 1'b0;
        end else if (hit) begin
            mem_ack <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 4'h1;
        end
    end
    // Table word on answer, churning data otherwise
    always_ff @(posedge aclk) begin
        if (hit) begin
            mem_rdata <= {mem.addr[15:0], 16'hC0DE};
        end else begin
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule : cpu_mem_model

//--- dv/cpu_exception_sequencer_assertions.sv
`timescale 1ns/1ps
module cpu_exception_sequencer_assertions
    import cpu_exception_sequencer_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Watched ports
    input wire logic power_on_reset_n,
    input wire logic bus_busy,
    input wire logic mem_ack,
    input wire mem_s mem,
    input wire logic pipe_flush,
    input wire logic pc_load,
    input wire logic sp_load,
    input wire logic [31:0] status_word,
    input wire logic [31:0] vector_base_reg
);
    // ========
    // Sequencing checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic rd;
    assign rd = mem.req && !mem.write;
    a_flush_push: assert property (pipe_flush |-> ##[0:2] (mem.req && mem.write))
        else $error("no push after flush");
    a_reset_init: assert property (rd && (mem.addr == 32'h0 || mem.addr == 32'h8)
        && !$past(mem.req) |-> vector_base_reg == 32'h0 && status_word[7:4] == 4'hF)
        else $error("reset init wrong");
    a_por_sp: assert property (rd && mem.addr == 32'h0 && mem_ack |=> rd && mem.addr == 32'h4)
        else $error("sp fetch not at 4");
    a_mrs_sp: assert property (rd && mem.addr == 32'h8 && mem_ack |=> rd && mem.addr == 32'hC)
        else $error("sp fetch not at 12");
    a_push_order: assert property (mem.req && mem.write && mem_ack
        |=> mem.req && (!mem.write || mem.addr == $past(mem.addr) - 32'h4))
        else $error("push order wrong");
    a_word_aligned: assert property (mem.req |-> mem.addr[1:0] == 2'h0)
        else $error("unaligned access");
    a_req_held: assert property (mem.req && !mem_ack |=> mem.req && $stable(mem.addr))
        else $error("request not held");
    a_load_read: assert property (pc_load |-> sp_load && $past(rd && mem_ack))
        else $error("load without fetch");
    a_mrs_bus: assert property (rd && mem.addr == 32'h8 && !$past(mem.req) |-> !$past(bus_busy))
        else $error("manual reset cut bus");
    a_por_hold: assert property (!power_on_reset_n ##1 !power_on_reset_n |-> !mem.req)
        else $error("bus used in reset");
endmodule : cpu_exception_sequencer_assertions

bind cpu_exception_sequencer cpu_exception_sequencer_assertions i_chk (.*);

//--- dv/cpu_exception_sequencer_tb.sv
`timescale 1ns/1ps
`include "cpu_exception_sequencer_regs.svh"
module cpu_exception_sequencer_tb
    import cpu_exception_sequencer_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, pc_value, sp_value, status_word, vector_base_reg, mem_rdata;
    logic power_on_reset_n = 1'b1, manual_reset_n = 1'b1, watchdog_overflow = 1'b0;
    logic exec_done = 1'b1, bus_busy = 1'b0, mem_ack;
    logic core_hold, pipe_flush, pc_load, sp_load, irq_ack;
    logic [31:0] core_pc = 32'h00002000, stack_pointer_gpr = 32'h00008000;
    logic [31:0] rd_a, w1a, w1d, w2a, w2d;
    logic [3:0] wait_cycles = 4'h0;
    dec_s dec = '0;
    irq_s irq = '0;
    mem_s mem;
    int err_total = 0, total_checks = 0;

    always #2.5 aclk = ~aclk;
    cpu_exception_sequencer i_dut (.*);
    cpu_mem_model i_mem (.aclk(aclk), .aresetn(aresetn), .mem(mem),
        .wait_cycles(wait_cycles), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    // Log completed bus transfers
    always @(posedge aclk) begin
        if (mem.req && mem_ack && mem.write) begin
            {w1a, w1d, w2a, w2d} <= {w2a, w2d, mem.addr, mem.wdata};
        end
        if (mem.req && mem_ack && !mem.write) rd_a <= mem.addr;
    end

    // ========
    // Shared tasks
    function automatic logic [31:0] tbl(input logic [31:0] a);
        return {a[15:0], 16'hC0DE};
    endfunction : tbl
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic stop_test();
        $display("Checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rsp);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        check("bresp", {30'h0, s_axi_bresp}, {30'h0, rsp});
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rsp);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        check("rdata", s_axi_rdata, d);
        check("rresp", {30'h0, s_axi_rresp}, {30'h0, rsp});
    endtask : axi_rd
    task automatic issue(input logic [4:0] f, input logic [7:0] imm, input logic [1:0] ae,
        input irq_s iv);
        do @(posedge aclk); while (core_hold !== 1'b0);
        dec <= {f, imm, ae};
        @(posedge aclk);
        dec <= '0;
        irq <= iv;
    endtask : issue
    task automatic expect_exc(input logic [31:0] ra, input logic [31:0] pcx,
        input logic [31:0] spx);
        do begin
            @(posedge aclk);
            #1;
        end while (pc_load !== 1'b1);
        check("fetch", rd_a, ra);
        check("pc", pc_value, pcx);
        check("sp", sp_value, spx);
    endtask : expect_exc
    task automatic exc(input logic [7:0] vec, input logic [31:0] sr, input logic [31:0] sr_new);
        logic [31:0] fa;
        fa = 32'h00001000 + {22'h0, vec, 2'h0};
        expect_exc(fa, tbl(fa), stack_pointer_gpr - 32'h8);
        check("sr slot", w1a, stack_pointer_gpr - 32'h4);
        check("sr data", w1d, sr);
        check("pc slot", w2a, stack_pointer_gpr - 32'h8);
        check("pc data", w2d, core_pc);
        check("status", status_word, sr_new);
    endtask : exc

    // ========
    // Scenarios
    task automatic t_power_on();
        expect_exc(32'h4, tbl(32'h0), tbl(32'h4));
        check("vbr", vector_base_reg, 32'h0);
        check("status", status_word, 32'h000000F0);
        for (int k = 0; k < 2; k++) begin
            @(posedge aclk);
            if (k == 0) power_on_reset_n <= 1'b0;
            else watchdog_overflow <= 1'b1;
            @(posedge aclk);
            watchdog_overflow <= 1'b0;
            repeat (3) @(posedge aclk);
            power_on_reset_n <= 1'b1;
            expect_exc(32'h4, tbl(32'h0), tbl(32'h4));
        end
        $display("power-on done");
    endtask : t_power_on
    task automatic t_regs();
        axi_rd(`VBR_OFFSET, `VBR_RESET, `RESP_OKAY);
        axi_rd(`STATUS_WORD_OFFSET, `STATUS_WORD_RESET, `RESP_OKAY);
        axi_wr(`VBR_OFFSET, 32'h00001000, `RESP_OKAY);
        axi_wr(`STATUS_WORD_OFFSET, 32'h00000030, `RESP_OKAY);
        axi_rd(`VBR_OFFSET, 32'h00001000, `RESP_OKAY);
        axi_wr(8'h10, 32'h00000001, `RESP_SLVERR);
        axi_rd(8'h10, 32'h0, `RESP_SLVERR);
        $display("registers done");
    endtask : t_regs
    task automatic t_instr();
        logic [4:0] fl[5] = '{5'h11, 5'h11, 5'h18, 5'h1C, 5'h16};
        logic [7:0] im[5] = '{8'h1F, 8'h00, 8'h00, 8'h00, 8'h00};
        logic [7:0] vv[5] = '{8'h3F, 8'h20, 8'h04, 8'h06, 8'h06};
        @(posedge aclk);
        wait_cycles <= 4'h3;
        for (int i = 0; i < 5; i++) begin
            issue(fl[i], im[i], 2'h0, '0);
            exc(vv[i], 32'h30, 32'h30);
        end
        $display("instruction done");
    endtask : t_instr
    task automatic t_addr();
        @(posedge aclk);
        exec_done <= 1'b0;
        issue(5'h10, 8'h00, 2'h3, '0);
        repeat (6) @(posedge aclk);
        #1;
        check("early start", {31'h0, mem.req}, 32'h0);
        @(posedge aclk);
        exec_done <= 1'b1;
        exc(8'h09, 32'h30, 32'h30);
        issue(5'h10, 8'h00, 2'h1, {1'b1, 4'h5, 8'h0B});
        exc(8'h0A, 32'h30, 32'h30);
        exc(8'h0B, 32'h30, 32'h50);
        @(posedge aclk);
        irq <= '0;
        $display("address error done");
    endtask : t_addr
    task automatic t_mrs();
        @(posedge aclk);
        {bus_busy, manual_reset_n} <= 2'h2;
        repeat (4) @(posedge aclk);
        manual_reset_n <= 1'b1;
        repeat (6) @(posedge aclk);
        #1;
        check("bus cut", {31'h0, mem.req}, 32'h0);
        @(posedge aclk);
        bus_busy <= 1'b0;
        expect_exc(32'hC, tbl(32'h8), tbl(32'hC));
        check("vbr", vector_base_reg, 32'h0);
        check("status", status_word, 32'h000000F0);
        $display("manual reset done");
    endtask : t_mrs

    // Main sequence
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_power_on();
        t_regs();
        t_instr();
        t_addr();
        t_mrs();
        stop_test();
    end
    // Hang guard
    initial begin
        repeat (20000) @(posedge aclk);
        err_total++;
        stop_test();
    end
endmodule : cpu_exception_sequencer_tb
